// file: t1_yellow_alarm_pkg.sv
// Constants, register map and types for the T1 yellow alarm generator.
// Assumes one 10 MHz system clock and an APB register port.
package t1_yellow_alarm_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS     = 100;
	localparam int ONE_SECOND_NS     = 1000000000;
	localparam int ONE_SECOND_CYCLES = ONE_SECOND_NS / CLK_PERIOD_NS;
	localparam int TIMER_WIDTH       = 24;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam int          ADDR_WIDTH             = 12;
	localparam logic [11:0] ALARM_GEN_CONTROL_ADDR = 12'h108;
	localparam logic [11:0] FRAMING_SELECT_ADDR    = 12'h10C;
	localparam logic [11:0] YELLOW_STATUS_ADDR     = 12'h110;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int         ONE_SECOND_RULE_BIT = 7;
	localparam int         YELLOW_TX_ENABLE_BIT = 6;
	localparam int         YELLOW_CTL_MSB      = 5;
	localparam int         YELLOW_CTL_LSB      = 4;
	localparam logic [7:0] ALARM_GEN_CONTROL_RESET = 8'h00;
	localparam logic [1:0] FRAMING_SELECT_RESET    = 2'h0;

	// Yellow control codes
	localparam logic [1:0] YELLOW_CTL_OFF = 2'h0;
	localparam logic [1:0] YELLOW_CTL_STD = 2'h1;

	// ------------------------------------------------------------
	// Data link pattern
	// ------------------------------------------------------------
	localparam logic [15:0] DL_RAI_PATTERN   = 16'hFF00;
	localparam logic [7:0]  DL_PATTERN_COUNT = 8'hFF;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		FRAMING_SF   = 2'h0,
		FRAMING_N    = 2'h1,
		FRAMING_T1_DATA_MUX_FRAMING = 2'h2,
		FRAMING_ESF  = 2'h3
	} framing_type;

	typedef enum logic [3:0] {
		RULE_IDLE   = 4'b0001,
		RULE_MIN    = 4'b0010,
		RULE_EXTEND = 4'b0100,
		RULE_GAP    = 4'b1000
	} rule_state_type;

endpackage

// file: one_second_timer.sv
// Down counter that measures one second of system clock.
// Assumes start is a one-cycle pulse from the same clock.
`timescale 1ns/10ps
`default_nettype none
module one_second_timer #(
	parameter int unsigned CYCLES = t1_yellow_alarm_pkg::ONE_SECOND_CYCLES
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic arst_n,
	// Control
	input  wire logic start,
	output var  logic running,
	output var  logic expired
);
	import t1_yellow_alarm_pkg::*;

	localparam logic [TIMER_WIDTH-1:0] LOAD = TIMER_WIDTH'(CYCLES - 1);

	logic [TIMER_WIDTH-1:0] count;

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			count   <= '0;
			running <= 1'b0;
			expired <= 1'b0;
		end else if (start) begin
			count   <= LOAD;
			running <= 1'b1;
			expired <= 1'b0;
		end else if (running && count == '0) begin
			running <= 1'b0;
			expired <= 1'b1;
		end else begin
			if (running)
				count <= count - 1'b1;
			expired <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// file: esf_rai_pattern.sv
// Data link RAI pattern source: eight ones, eight zeros, 255 repeats.
// Assumes bit_req pulses once per outbound data link bit.
`timescale 1ns/10ps
`default_nettype none
module esf_rai_pattern (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic arst_n,
	// Control
	input  wire logic restart,
	input  wire logic abort,
	input  wire logic hold,
	input  wire logic bit_req,
	// Pattern
	output var  logic busy,
	output var  logic pattern_bit
);
	import t1_yellow_alarm_pkg::*;

	logic [3:0] bit_index;
	logic [7:0] pattern_count;
	logic       sending;

	assign sending     = busy || hold;
	assign pattern_bit = DL_RAI_PATTERN[4'hF - bit_index];

	// ------------------------------------------------------------
	// Bit and pattern counters
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			bit_index     <= 4'h0;
			pattern_count <= 8'h00;
			busy          <= 1'b0;
		end else if (abort) begin
			bit_index     <= 4'h0;
			pattern_count <= 8'h00;
			busy          <= 1'b0;
		end else if (restart) begin
			bit_index     <= 4'h0;
			pattern_count <= 8'h00;
			busy          <= 1'b1;
		end else if (sending && bit_req) begin
			bit_index <= bit_index + 4'h1;
			if (bit_index == 4'hF) begin
				if (pattern_count == DL_PATTERN_COUNT - 8'h01)
					busy <= 1'b0;
				if (pattern_count != DL_PATTERN_COUNT)
					pattern_count <= pattern_count + 8'h01;
			end
		end else if (!sending) begin
			bit_index <= 4'h0;
		end
	end

endmodule
`default_nettype wire

// file: t1_yellow_alarm_generator.sv
// Transmit yellow alarm (RAI) generator for one T1 framer channel.
// Assumes an APB master on clk_sys and framer strobes on the same clock.
//
// Overview of operation
// - Under one-second rule, RAI lasts at least one second once started.
// - Under one-second rule, new RAI waits one second after previous ends.
// - Under one-second rule, transmit enable sets duration; framing select sets format.
// - Under one-second rule, insertion format comes only from the framing select; yellow field ignored.
// - Without the rule, no minimum gap between consecutive RAI periods.
// - Without the rule, yellow field sets duration; framing select sets format.
// - Top control bit selects the rule: 0 off, 1 enforced, resets to 0.
// - Under the rule, enable 1 starts RAI, 0 stops it after the minimum.
// - Transmit enable is ignored when the rule is off.
// - Without the rule, yellow code 00 disables RAI except a running ESF pattern; it is the reset value.
// - Code 01 in SF or N forces bit 2 of every DS0 to zero.
// - Code 01 in data mux framing forces the sync byte Y-bit to zero.
// - ESF code 01 pulse sends 255 ones/zeros patterns; long level continues.
// - A new ESF pulse during RAI restarts the 255-pattern count.
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module t1_yellow_alarm_generator #(
	parameter int unsigned ONE_SECOND = t1_yellow_alarm_pkg::ONE_SECOND_CYCLES
) (
	// Clock and reset
	input  wire logic                                   clk_sys,
	input  wire logic                                   arst_n,
	// APB slave
	input  wire logic                                   psel,
	input  wire logic                                   penable,
	input  wire logic                                   pwrite,
	input  wire logic [t1_yellow_alarm_pkg::ADDR_WIDTH-1:0] paddr,
	input  wire logic [31:0]                            pwdata,
	input  wire logic [3:0]                             pstrb,
	output var  logic [31:0]                            prdata,
	output var  logic                                   pready,
	output var  logic                                   pslverr,
	// Framer data link strobe
	input  wire logic                                   dl_bit_req,
	// RAI insertion controls
	output var  logic                                   rai_active,
	output var  logic                                   ds0_bit2_zero,
	output var  logic                                   ybit_zero,
	output var  logic                                   dl_rai_insert,
	output var  logic                                   dl_rai_bit
);
	import t1_yellow_alarm_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [7:0]     alarm_generation_control;
	framing_type    framing;
	rule_state_type rule_state;
	rule_state_type next_rule_state;

	logic       one_second_rule;
	logic       yellow_tx_enable;
	logic [1:0] yellow_ctl;
	logic       yellow_ctl_low_prev;

	logic       apb_access;
	logic       apb_done;
	logic       addr_hit;
	logic       wr_lane0;
	logic [31:0] read_mux;

	logic timer_start;
	logic timer_running;
	logic timer_expired;

	logic pulse_restart;
	logic pattern_hold;
	logic pattern_busy;
	logic pattern_bit;

	logic rule_rai;
	logic free_rai;
	logic next_rai;
	logic esf_mode;
	logic code_std;
	logic in_gap;
	logic sf_format;
	logic dm_format;
	logic low_bit_rise;
	logic pattern_abort;
	logic wr_control;
	logic wr_framing;

	// ------------------------------------------------------------
	// Control field decode
	// ------------------------------------------------------------
	assign one_second_rule  = alarm_generation_control[ONE_SECOND_RULE_BIT];
	assign yellow_tx_enable = alarm_generation_control[YELLOW_TX_ENABLE_BIT];
	assign yellow_ctl       = alarm_generation_control[YELLOW_CTL_MSB:YELLOW_CTL_LSB];
	assign esf_mode         = (framing == FRAMING_ESF);
	assign code_std         = (yellow_ctl == YELLOW_CTL_STD);
	assign in_gap           = (rule_state == RULE_GAP);

	// ------------------------------------------------------------
	// APB slave, one wait state on every access
	// ------------------------------------------------------------
	assign apb_access = psel && penable;
	assign apb_done   = apb_access && pready;
	assign wr_lane0   = apb_done && pwrite && pstrb[0] && !pslverr;
	assign wr_control = wr_lane0 && paddr == ALARM_GEN_CONTROL_ADDR;
	assign wr_framing = wr_lane0 && paddr == FRAMING_SELECT_ADDR;

	assign addr_hit = (paddr == ALARM_GEN_CONTROL_ADDR)
		|| (paddr == FRAMING_SELECT_ADDR)
		|| (paddr == YELLOW_STATUS_ADDR);

	always_comb begin
		read_mux = 32'h0000_0000;
		unique case (paddr)
			ALARM_GEN_CONTROL_ADDR: read_mux[7:0] = alarm_generation_control;
			FRAMING_SELECT_ADDR:    read_mux[1:0] = framing;
			YELLOW_STATUS_ADDR: begin
				read_mux[0]   = rai_active;
				read_mux[1]   = in_gap;
				read_mux[2]   = pattern_busy;
				read_mux[7:4] = rule_state;
			end
			default:                read_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (apb_access && !pready) begin
			pready  <= 1'b1;
			pslverr <= !addr_hit;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			prdata <= 32'h0000_0000;
		else if (apb_access && !pready)
			prdata <= pwrite ? 32'h0000_0000 : read_mux;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			alarm_generation_control <= ALARM_GEN_CONTROL_RESET;
		else if (wr_control)
			alarm_generation_control <= pwdata[7:0];
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			framing <= framing_type'(FRAMING_SELECT_RESET);
		else if (wr_framing)
			framing <= framing_type'(pwdata[1:0]);
	end

	// ------------------------------------------------------------
	// One-second rule sequencer
	// ------------------------------------------------------------
	always_comb begin
		next_rule_state = rule_state;
		timer_start     = 1'b0;
		if (!one_second_rule) begin
			next_rule_state = RULE_IDLE;
		end else begin
			unique case (rule_state)
				RULE_IDLE: begin
					if (yellow_tx_enable) begin
						next_rule_state = RULE_MIN;
						timer_start     = 1'b1;
					end
				end
				RULE_MIN: begin
					if (timer_expired) begin
						if (yellow_tx_enable) begin
							next_rule_state = RULE_EXTEND;
						end else begin
							next_rule_state = RULE_GAP;
							timer_start     = 1'b1;
						end
					end
				end
				RULE_EXTEND: begin
					if (!yellow_tx_enable) begin
						next_rule_state = RULE_GAP;
						timer_start     = 1'b1;
					end
				end
				RULE_GAP: begin
					if (timer_expired)
						next_rule_state = RULE_IDLE;
				end
				default: next_rule_state = RULE_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			rule_state <= RULE_IDLE;
		else
			rule_state <= next_rule_state;
	end

	one_second_timer #(
		.CYCLES (ONE_SECOND)
	) u_timer (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.start   (timer_start),
		.running (timer_running),
		.expired (timer_expired)
	);

	// ------------------------------------------------------------
	// ESF data link pattern
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			yellow_ctl_low_prev <= 1'b0;
		else
			yellow_ctl_low_prev <= yellow_ctl[0];
	end

	// Rising edge of the low yellow bit starts or extends a pattern run
	assign low_bit_rise  = yellow_ctl[0] && !yellow_ctl_low_prev;
	assign pulse_restart = !one_second_rule && esf_mode && code_std
		&& low_bit_rise;
	assign pattern_hold  = one_second_rule ? rule_rai
		: (esf_mode && code_std);
	// Enforced mode clears leftovers and runs the pattern only during RAI
	assign pattern_abort = !esf_mode || (one_second_rule && !rule_rai);

	esf_rai_pattern u_pattern (
		.clk_sys     (clk_sys),
		.arst_n      (arst_n),
		.restart     (pulse_restart),
		.abort       (pattern_abort),
		.hold        (pattern_hold),
		.bit_req     (dl_bit_req),
		.busy        (pattern_busy),
		.pattern_bit (pattern_bit)
	);

	// ------------------------------------------------------------
	// RAI decision
	// ------------------------------------------------------------
	assign rule_rai = (rule_state == RULE_MIN) || (rule_state == RULE_EXTEND);
	assign free_rai = esf_mode ? (pattern_busy || code_std)
		: code_std;
	assign next_rai = one_second_rule ? rule_rai : free_rai;

	// ------------------------------------------------------------
	// Format select
	// ------------------------------------------------------------
	assign sf_format = (framing == FRAMING_SF) || (framing == FRAMING_N);
	assign dm_format = (framing == FRAMING_T1_DATA_MUX_FRAMING);

	// ------------------------------------------------------------
	// Insertion outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			rai_active <= 1'b0;
		else
			rai_active <= next_rai;
	end

	// Enforced alarms use the code 01 format of the framing
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			ds0_bit2_zero <= 1'b0;
		else
			ds0_bit2_zero <= next_rai && sf_format;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			ybit_zero <= 1'b0;
		else
			ybit_zero <= next_rai && dm_format;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			dl_rai_insert <= 1'b0;
		else
			dl_rai_insert <= next_rai && esf_mode;
	end

	// Pattern bit only while the data link carries RAI
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			dl_rai_bit <= 1'b0;
		else
			dl_rai_bit <= next_rai && esf_mode && pattern_bit;
	end

endmodule
`default_nettype wire

// file: t1_yellow_alarm_generator_asserts.sv
// Port assertions for the yellow alarm generator.
// Assumes an APB master and one clock domain.
`timescale 1ns/10ps
`default_nettype none
module yellow_alarm_checker #(
	parameter int unsigned ONE_SECOND = 20
) (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        arst_n,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Line side
	input wire logic        dl_bit_req,
	input wire logic        rai_active,
	input wire logic        ds0_bit2_zero,
	input wire logic        ybit_zero,
	input wire logic        dl_rai_insert,
	input wire logic        dl_rai_bit
);
	import t1_yellow_alarm_pkg::*;
	logic        mode;
	int unsigned on_cnt;
	int unsigned off_cnt;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			mode <= 1'b0;
		else if (psel && penable && pready && pwrite && pstrb[0] && paddr == ALARM_GEN_CONTROL_ADDR)
			mode <= pwdata[ONE_SECOND_RULE_BIT];
	end
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			on_cnt  <= 0;
			off_cnt <= ONE_SECOND;
		end else begin
			on_cnt  <= rai_active ? on_cnt + 1 : 0;
			off_cnt <= rai_active ? 0 : (off_cnt < ONE_SECOND ? off_cnt + 1 : off_cnt);
		end
	end
	pready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
	wait_state_a: assert property (psel && penable && !pready |=> pready) else $error("no answer");
	err_with_ready_a: assert property (pslverr |-> pready) else $error("stray pslverr");
	err_data_zero_a: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
	upper_read_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits");
	format_exclusive_a: assert property (!(ds0_bit2_zero && ybit_zero)) else $error("two formats");
	format_needs_rai_a: assert property (ds0_bit2_zero || ybit_zero || dl_rai_insert |-> rai_active)
		else $error("format without alarm");
	min_duration_a: assert property ($fell(rai_active) && mode |-> on_cnt >= ONE_SECOND)
		else $error("alarm too short");
	min_gap_a: assert property ($rose(rai_active) && mode |-> off_cnt >= ONE_SECOND)
		else $error("gap too short");
endmodule
bind t1_yellow_alarm_generator yellow_alarm_checker #(.ONE_SECOND(ONE_SECOND)) i_checker (
	.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .dl_bit_req(dl_bit_req), .rai_active(rai_active),
	.ds0_bit2_zero(ds0_bit2_zero), .ybit_zero(ybit_zero), .dl_rai_insert(dl_rai_insert),
	.dl_rai_bit(dl_rai_bit));
`default_nettype wire

// file: remote_terminal_model.sv
// Far end model: data link bit strobe and alarm pattern tally.
// Assumes the generator clock.
`timescale 1ns/10ps
`default_nettype none
module remote_terminal_model (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic arst_n,
	// Data link
	input  wire logic dl_rai_insert,
	input  wire logic dl_rai_bit,
	output var  logic dl_bit_req,
	// Tally
	output var  int   n_req,
	output var  int   n_ones
);
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			dl_bit_req <= 1'b0;
		else
			dl_bit_req <= !dl_bit_req;
	end
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			n_req  <= 0;
			n_ones <= 0;
		end else if (dl_bit_req && dl_rai_insert) begin
			n_req  <= n_req + 1;
			n_ones <= n_ones + int'(dl_rai_bit);
		end
	end
endmodule
`default_nettype wire

// file: tb_t1_yellow_alarm_generator.sv
// Self-checking bench for the yellow alarm generator.
// Assumes the design package and the far end model.
`timescale 1ns/10ps
`default_nettype none
module tb_t1_yellow_alarm_generator;
	import t1_yellow_alarm_pkg::*;
	localparam int unsigned ONE_S = 20;
	logic        clk_sys = 0;
	logic        arst_n  = 0;
	logic        psel    = 0;
	logic        penable = 0;
	logic        pwrite  = 0;
	logic [11:0] paddr   = '0;
	logic [31:0] pwdata  = '0;
	logic [3:0]  pstrb   = 4'hF;
	logic [31:0] prdata, rd;
	logic [31:0] rnd     = 32'h78EB607C;
	logic        pready, pslverr, dl_bit_req, rai_active, ds0_bit2_zero, ybit_zero;
	logic        dl_rai_insert, dl_rai_bit, err;
	logic [1:0]  f;
	logic [7:0]  c;
	int          n_errors = 0;
	int          checked  = 0;
	int          n_req, n_ones, cnt, n0, o0;
	always #50 clk_sys = ~clk_sys;
	t1_yellow_alarm_generator #(.ONE_SECOND(ONE_S)) i_t1_yellow_alarm_generator (
		.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dl_bit_req(dl_bit_req), .rai_active(rai_active),
		.ds0_bit2_zero(ds0_bit2_zero), .ybit_zero(ybit_zero), .dl_rai_insert(dl_rai_insert),
		.dl_rai_bit(dl_rai_bit));
	remote_terminal_model i_remote_terminal_model (.clk_sys(clk_sys), .arst_n(arst_n),
		.dl_rai_insert(dl_rai_insert), .dl_rai_bit(dl_rai_bit), .dl_bit_req(dl_bit_req),
		.n_req(n_req), .n_ones(n_ones));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [2:0] exp_out(input logic [7:0] v, input logic [1:0] fr);
		logic r;
		r = v[5:4] == YELLOW_CTL_STD;
		return {r, r && fr < 2'h2, r && fr == 2'h2};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 20)
			check(32'h0, 32'h1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_rai(input logic lvl, input int lim);
		cnt = 0;
		while (rai_active !== lvl && cnt < lim) begin
			@(posedge clk_sys);
			cnt++;
		end
	endtask
	task automatic end_sim;
		$display("mismatches %0d of %0d checks", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		cyc(5);
		arst_n <= 1'b1;
		apb(1'b0, ALARM_GEN_CONTROL_ADDR, 32'h0);
		check(rd, {24'h0, ALARM_GEN_CONTROL_RESET});
		check({rai_active, ds0_bit2_zero, ybit_zero, dl_rai_insert}, 4'h0);
		apb(1'b1, 12'h200, 32'hFF);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		for (int i = 0; i < 28; i++) begin
			rnd = lfsr(rnd);
			f = rnd[9:8] == 2'h3 ? 2'h0 : rnd[9:8];
			c = i < 4 ? 8'h50 >> (i * 2) : {1'b0, rnd[6:0]};
			apb(1'b1, FRAMING_SELECT_ADDR, {30'h0, f});
			apb(1'b1, ALARM_GEN_CONTROL_ADDR, {24'h0, c});
			cyc(3);
			check(rai_active, exp_out(c, f) >> 2);
			check({ds0_bit2_zero, ybit_zero}, exp_out(c, f) & 3'h3);
			apb(1'b0, ALARM_GEN_CONTROL_ADDR, 32'h0);
			check(rd, {24'h0, c});
		end
		apb(1'b1, ALARM_GEN_CONTROL_ADDR, 32'h10);
		apb(1'b1, ALARM_GEN_CONTROL_ADDR, 32'h00);
		apb(1'b1, ALARM_GEN_CONTROL_ADDR, 32'h10);
		cyc(3);
		check(rai_active, 1'b1);
		apb(1'b1, FRAMING_SELECT_ADDR, 32'h0);
		apb(1'b1, ALARM_GEN_CONTROL_ADDR, 32'h00);
		cyc(ONE_S + 5);
		apb(1'b1, ALARM_GEN_CONTROL_ADDR, 32'hD0);
		apb(1'b1, ALARM_GEN_CONTROL_ADDR, 32'h90);
		check(ds0_bit2_zero, 1'b1);
		wait_rai(1'b0, 200);
		check(cnt > ONE_S - 9 && cnt < ONE_S + 2, 1'b1);
		apb(1'b1, ALARM_GEN_CONTROL_ADDR, 32'hC0);
		cyc(10);
		check(rai_active, 1'b0);
		wait_rai(1'b1, 60);
		check(rai_active, 1'b1);
		cyc(2 * ONE_S);
		check(rai_active, 1'b1);
		apb(1'b1, ALARM_GEN_CONTROL_ADDR, 32'h80);
		wait_rai(1'b0, 60);
		check(rai_active, 1'b0);
		apb(1'b1, ALARM_GEN_CONTROL_ADDR, 32'h00);
		cyc(ONE_S + 5);
		apb(1'b1, FRAMING_SELECT_ADDR, 32'h3);
		apb(1'b1, ALARM_GEN_CONTROL_ADDR, 32'h10);
		apb(1'b1, ALARM_GEN_CONTROL_ADDR, 32'h00);
		wait_rai(1'b0, 10000);
		check((n_req + 8) / 16, 255);
		check(n_ones > 2029 && n_ones < 2051, 1'b1);
		// Second pulse in mid-run restarts the pattern count
		apb(1'b1, ALARM_GEN_CONTROL_ADDR, 32'h10);
		apb(1'b1, ALARM_GEN_CONTROL_ADDR, 32'h00);
		cyc(400);
		check(rai_active, 1'b1);
		n0 = n_req;
		apb(1'b1, ALARM_GEN_CONTROL_ADDR, 32'h10);
		apb(1'b1, ALARM_GEN_CONTROL_ADDR, 32'h00);
		wait_rai(1'b0, 10000);
		check((n_req - n0 + 8) / 16, 255);
		// Enforced alarm in ESF keeps the ones/zeros pattern
		cyc(ONE_S + 5);
		apb(1'b1, ALARM_GEN_CONTROL_ADDR, 32'hD0);
		n0 = n_req;
		o0 = n_ones;
		cyc(64);
		check(dl_rai_insert, 1'b1);
		check((n_ones - o0) * 2 + 2 >= n_req - n0 && (n_ones - o0) * 2 <= n_req - n0 + 2, 1'b1);
		apb(1'b0, YELLOW_STATUS_ADDR, 32'h0);
		check(rd, {24'h0, RULE_EXTEND, 4'h1});
		apb(1'b1, ALARM_GEN_CONTROL_ADDR, 32'h80);
		wait_rai(1'b0, 60);
		apb(1'b0, YELLOW_STATUS_ADDR, 32'h0);
		check(rd, {24'h0, RULE_GAP, 4'h2});
		end_sim();
	end
	initial begin
		#(100 * 40000);
		n_errors++;
		end_sim();
	end
endmodule
`default_nettype wire
